// file: hw/regulator_control_map.svh
// register offsets, field positions and reset values for the regulator control bank
`ifndef REGULATOR_CONTROL_MAP_SVH
`define REGULATOR_CONTROL_MAP_SVH
`define ADDR_SECOND_BUCK_MODE_ENABLE  8'h04
`define ADDR_SECOND_BUCK_LIMIT_SLEW   8'h05
`define ADDR_FIRST_BUCK_VOLTAGE_CODE  8'h06
`define ADDR_SECOND_BUCK_VOLTAGE_CODE 8'h07
`define ADDR_FIRST_LINEAR_CONTROL     8'h08
`define BIT_FORCED_PWM                3
`define BIT_DISCHARGE                 2
`define BIT_PIN_GATING                1
`define BIT_ENABLE                    0
`define LIMIT_MSB                     5
`define LIMIT_LSB                     3
`define SLEW_MSB                      2
`define SLEW_LSB                      0
`define RST_SECOND_BUCK_MODE_ENABLE   8'h07
`define RST_SECOND_BUCK_LIMIT_SLEW    8'h2a
`define RST_VOLTAGE_CODE              8'h59
`define RST_FIRST_LINEAR_CONTROL      8'h07
`define MASK_SECOND_BUCK_MODE_ENABLE  8'h0f
`define MASK_SECOND_BUCK_LIMIT_SLEW   8'h3f
`define MASK_FIRST_LINEAR_CONTROL     8'h07
`define MASK_VOLTAGE_CODE             8'hff
`endif

// file: hw/regulator_control_pkg.sv
// types shared by the regulator control bank
package regulator_control_pkg;
  // register access request from the serial port front end
  typedef struct packed {
    logic       wr_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;
  // controls presented to the second buck core
  typedef struct packed {
    logic       forced_pulse_width;
    logic       discharge_on;
    logic       run;
    logic [2:0] current_limit;
    logic [2:0] slew_select;
    logic [7:0] voltage_code;
  } buck_ctrl_s;
  // controls presented to the first linear core
  typedef struct packed {
    logic discharge_on;
    logic run;
  } linear_ctrl_s;
endpackage : regulator_control_pkg

// file: hw/regulator_control_registers.sv
// control register bank for the second buck, both buck voltages and the first linear regulator
`timescale 1ns/1ps
`include "regulator_control_map.svh"

// Overview of operation
// - bit 3 of mode register picks auto pfm/pwm (0) or forced pwm (1), reset 0.
// - bit 2 applies second buck discharge resistor while disabled, reset 1.
// - bit 1 set means second buck needs enable bit and pin both, reset 1.
// - bit 0 enables second buck, reset 1.
// - limit field bits 5:3, codes 0..5 give 1.5..4.0 A, reset 5.
// - slew field bits 2:0, codes 2..7 give 10..0.47 mV/us, reset 2.
// - voltage codes below 0x14 reserved; 0x14..0x17 step 10 mV from 0.7 V.
// - voltage codes 0x18..0x9d step 5 mV from 0.735 V to 1.4 V.
// - voltage codes 0x9e..0xff step 20 mV from 1.42 V to 3.36 V.
// - both voltage code registers are full eight bit read/write, reset 0x59.
// - bit 2 applies first linear discharge resistor while disabled, reset 1.
// - bit 1 set means first linear needs enable bit and pin both, reset 1.
// - bit 0 enables first linear regulator, reset 1.
module regulator_control_registers
  import regulator_control_pkg::*;
(
  input  wire logic         core_clk,     // 100 mhz clock
  input  wire logic         reset,        // synchronous, active high
  input  wire reg_req_s     req,          // register request, one cycle
  input  wire logic         req_valid,    // request strobe
  input  wire logic         enable_pin,   // external enable pin, asynchronous
  output logic [7:0]        rdata,        // read data, registered
  output logic              rdata_valid,  // read answer pulse
  output buck_ctrl_s        buck_ctrl,    // second buck controls
  output logic [7:0]        first_buck_voltage_code, // first buck voltage code
  output linear_ctrl_s      linear_ctrl   // first linear controls
);

  logic [7:0] mode_r, mode_nxt;
  logic [7:0] limit_r, limit_nxt;
  logic [7:0] vfirst_r, vfirst_nxt;
  logic [7:0] vsecond_r, vsecond_nxt;
  logic [7:0] linear_r, linear_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic       rvalid_r, rvalid_nxt;
  logic       pin_meta_r, pin_sync_r;
  buck_ctrl_s   buck_r, buck_nxt;
  logic [7:0]   vout_r, vout_nxt;
  linear_ctrl_s lin_r, lin_nxt;

  // register writes; reserved upper bits are held at zero
  always_comb
  begin
    mode_nxt    = mode_r;
    limit_nxt   = limit_r;
    vfirst_nxt  = vfirst_r;
    vsecond_nxt = vsecond_r;
    linear_nxt  = linear_r;
    if (req_valid && req.wr_en)
    begin
      case (req.addr)
        `ADDR_SECOND_BUCK_MODE_ENABLE:  mode_nxt    = req.wdata & `MASK_SECOND_BUCK_MODE_ENABLE;
        `ADDR_SECOND_BUCK_LIMIT_SLEW:   limit_nxt   = req.wdata & `MASK_SECOND_BUCK_LIMIT_SLEW;
        `ADDR_FIRST_BUCK_VOLTAGE_CODE:  vfirst_nxt  = req.wdata;
        `ADDR_SECOND_BUCK_VOLTAGE_CODE: vsecond_nxt = req.wdata;
        `ADDR_FIRST_LINEAR_CONTROL:     linear_nxt  = req.wdata & `MASK_FIRST_LINEAR_CONTROL;
        default:                        mode_nxt    = mode_r;
      endcase
    end
  end

  // read mux; unmapped addresses read zero
  always_comb
  begin
    rvalid_nxt = req_valid && !req.wr_en;
    rdata_nxt  = rdata_r;
    if (req_valid && !req.wr_en)
    begin
      case (req.addr)
        `ADDR_SECOND_BUCK_MODE_ENABLE:  rdata_nxt = mode_r;
        `ADDR_SECOND_BUCK_LIMIT_SLEW:   rdata_nxt = limit_r;
        `ADDR_FIRST_BUCK_VOLTAGE_CODE:  rdata_nxt = vfirst_r;
        `ADDR_SECOND_BUCK_VOLTAGE_CODE: rdata_nxt = vsecond_r;
        `ADDR_FIRST_LINEAR_CONTROL:     rdata_nxt = linear_r;
        default:                        rdata_nxt = 8'h00;
      endcase
    end
  end

  // core controls with pin gating; voltage codes pass unchanged to the cores
  always_comb
  begin
    buck_nxt.forced_pulse_width = mode_r[`BIT_FORCED_PWM];
    buck_nxt.discharge_on       = mode_r[`BIT_DISCHARGE];
    buck_nxt.run                = mode_r[`BIT_ENABLE]
                                  && (!mode_r[`BIT_PIN_GATING] || pin_sync_r);
    buck_nxt.current_limit      = limit_r[`LIMIT_MSB:`LIMIT_LSB];
    buck_nxt.slew_select        = limit_r[`SLEW_MSB:`SLEW_LSB];
    buck_nxt.voltage_code       = vsecond_r;
    vout_nxt                    = vfirst_r;
    lin_nxt.discharge_on        = linear_r[`BIT_DISCHARGE];
    lin_nxt.run                 = linear_r[`BIT_ENABLE]
                                  && (!linear_r[`BIT_PIN_GATING] || pin_sync_r);
  end

  // state registers
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      mode_r     <= `RST_SECOND_BUCK_MODE_ENABLE;
      limit_r    <= `RST_SECOND_BUCK_LIMIT_SLEW;
      vfirst_r   <= `RST_VOLTAGE_CODE;
      vsecond_r  <= `RST_VOLTAGE_CODE;
      linear_r   <= `RST_FIRST_LINEAR_CONTROL;
      rdata_r    <= 8'h00;
      rvalid_r   <= 1'b0;
      pin_meta_r <= 1'b0;
      pin_sync_r <= 1'b0;
      buck_r     <= '0;
      vout_r     <= `RST_VOLTAGE_CODE;
      lin_r      <= '0;
    end
    else
    begin
      mode_r     <= mode_nxt;
      limit_r    <= limit_nxt;
      vfirst_r   <= vfirst_nxt;
      vsecond_r  <= vsecond_nxt;
      linear_r   <= linear_nxt;
      rdata_r    <= rdata_nxt;
      rvalid_r   <= rvalid_nxt;
      pin_meta_r <= enable_pin;
      pin_sync_r <= pin_meta_r;
      buck_r     <= buck_nxt;
      vout_r     <= vout_nxt;
      lin_r      <= lin_nxt;
    end
  end

  assign rdata                   = rdata_r;
  assign rdata_valid             = rvalid_r;
  assign buck_ctrl               = buck_r;
  assign first_buck_voltage_code = vout_r;
  assign linear_ctrl             = lin_r;

  // write request to a given register
  sequence s_write(logic [7:0] a);
    req_valid && req.wr_en && req.addr == a;
  endsequence

  // read request to a given register
  sequence s_read(logic [7:0] a);
    req_valid && !req.wr_en && req.addr == a;
  endsequence

  property p_mode_pwm;
    @(posedge core_clk) disable iff (reset)
    s_write(`ADDR_SECOND_BUCK_MODE_ENABLE) |->
      ##2 buck_ctrl.forced_pulse_width == $past(req.wdata[`BIT_FORCED_PWM], 2);
  endproperty
  a_mode_pwm: assert property (p_mode_pwm) else $error("forced pwm not following write");

  property p_buck_discharge;
    @(posedge core_clk) disable iff (reset)
    s_write(`ADDR_SECOND_BUCK_MODE_ENABLE) |->
      ##2 buck_ctrl.discharge_on == $past(req.wdata[`BIT_DISCHARGE], 2);
  endproperty
  a_buck_discharge: assert property (p_buck_discharge) else $error("buck discharge wrong");

  property p_buck_gating;
    @(posedge core_clk) disable iff (reset)
    (mode_r[`BIT_PIN_GATING] && mode_r[`BIT_ENABLE] && !pin_sync_r) |=> !buck_ctrl.run;
  endproperty
  a_buck_gating: assert property (p_buck_gating) else $error("buck runs with pin low");

  property p_buck_enable;
    @(posedge core_clk) disable iff (reset)
    !mode_r[`BIT_ENABLE] |=> !buck_ctrl.run;
  endproperty
  a_buck_enable: assert property (p_buck_enable) else $error("buck runs while disabled");

  property p_limit;
    @(posedge core_clk) disable iff (reset)
    s_write(`ADDR_SECOND_BUCK_LIMIT_SLEW) |->
      ##2 buck_ctrl.current_limit == $past(req.wdata[`LIMIT_MSB:`LIMIT_LSB], 2);
  endproperty
  a_limit: assert property (p_limit) else $error("current limit wrong");

  property p_slew;
    @(posedge core_clk) disable iff (reset)
    s_write(`ADDR_SECOND_BUCK_LIMIT_SLEW) |->
      ##2 buck_ctrl.slew_select == $past(req.wdata[`SLEW_MSB:`SLEW_LSB], 2);
  endproperty
  a_slew: assert property (p_slew) else $error("slew select wrong");

  property p_vout;
    @(posedge core_clk) disable iff (reset)
    s_write(`ADDR_SECOND_BUCK_VOLTAGE_CODE) |-> ##2 buck_ctrl.voltage_code == $past(req.wdata, 2);
  endproperty
  a_vout: assert property (p_vout) else $error("voltage code wrong");

  property p_lin_gating;
    @(posedge core_clk) disable iff (reset)
    (linear_r[`BIT_PIN_GATING] && !pin_sync_r) |=> !linear_ctrl.run;
  endproperty
  a_lin_gating: assert property (p_lin_gating) else $error("linear runs with pin low");

  property p_lin_enable;
    @(posedge core_clk) disable iff (reset)
    (linear_r[`BIT_ENABLE] && !linear_r[`BIT_PIN_GATING]) |=> linear_ctrl.run;
  endproperty
  a_lin_enable: assert property (p_lin_enable) else $error("linear not running");

  property p_readback;
    @(posedge core_clk) disable iff (reset)
    s_read(`ADDR_FIRST_LINEAR_CONTROL) |=> rdata == $past(linear_r) && rdata_valid;
  endproperty
  a_readback: assert property (p_readback) else $error("readback wrong");

  property p_lin_discharge;
    @(posedge core_clk) disable iff (reset)
    s_write(`ADDR_FIRST_LINEAR_CONTROL) |-> ##2 linear_ctrl.discharge_on == $past(req.wdata[`BIT_DISCHARGE], 2);
  endproperty
  a_lin_discharge: assert property (p_lin_discharge) else $error("linear discharge wrong");

  property p_first_vout;
    @(posedge core_clk) disable iff (reset)
    s_write(`ADDR_FIRST_BUCK_VOLTAGE_CODE) |-> ##2 first_buck_voltage_code == $past(req.wdata, 2);
  endproperty
  a_first_vout: assert property (p_first_vout) else $error("first voltage code wrong");

  property p_buck_pin_run;
    @(posedge core_clk) disable iff (reset)
    (mode_r[`BIT_ENABLE] && mode_r[`BIT_PIN_GATING] && pin_sync_r) |=> buck_ctrl.run;
  endproperty
  a_buck_pin_run: assert property (p_buck_pin_run) else $error("buck stopped with pin high");

  property p_buck_ungated;
    @(posedge core_clk) disable iff (reset)
    (mode_r[`BIT_ENABLE] && !mode_r[`BIT_PIN_GATING]) |=> buck_ctrl.run;
  endproperty
  a_buck_ungated: assert property (p_buck_ungated) else $error("buck not running");

  property p_lin_pin_run;
    @(posedge core_clk) disable iff (reset)
    (linear_r[`BIT_ENABLE] && linear_r[`BIT_PIN_GATING] && pin_sync_r) |=> linear_ctrl.run;
  endproperty
  a_lin_pin_run: assert property (p_lin_pin_run) else $error("linear stopped with pin high");

  property p_lin_off;
    @(posedge core_clk) disable iff (reset)
    !linear_r[`BIT_ENABLE] |=> !linear_ctrl.run;
  endproperty
  a_lin_off: assert property (p_lin_off) else $error("linear runs while disabled");

  property p_rvalid_pulse;
    @(posedge core_clk) disable iff (reset)
    !(req_valid && !req.wr_en) |=> !rdata_valid;
  endproperty
  a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read valid without read");

  property p_rdata_hold;
    @(posedge core_clk) disable iff (reset)
    !(req_valid && !req.wr_en) |=> $stable(rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without read");

  property p_mode_readback;
    @(posedge core_clk) disable iff (reset)
    s_read(`ADDR_SECOND_BUCK_MODE_ENABLE) |=> rdata == $past(mode_r) && rdata_valid;
  endproperty
  a_mode_readback: assert property (p_mode_readback) else $error("mode readback wrong");

  property p_limit_readback;
    @(posedge core_clk) disable iff (reset)
    s_read(`ADDR_SECOND_BUCK_LIMIT_SLEW) |=> rdata == $past(limit_r) && rdata_valid;
  endproperty
  a_limit_readback: assert property (p_limit_readback) else $error("limit readback wrong");

  property p_first_vcode_readback;
    @(posedge core_clk) disable iff (reset)
    s_read(`ADDR_FIRST_BUCK_VOLTAGE_CODE) |=> rdata == $past(vfirst_r) && rdata_valid;
  endproperty
  a_first_vcode_readback: assert property (p_first_vcode_readback) else $error("first code readback wrong");

  property p_second_vcode_readback;
    @(posedge core_clk) disable iff (reset)
    s_read(`ADDR_SECOND_BUCK_VOLTAGE_CODE) |=> rdata == $past(vsecond_r) && rdata_valid;
  endproperty
  a_second_vcode_readback: assert property (p_second_vcode_readback) else $error("second code readback bad");

  property p_unmapped_read;
    @(posedge core_clk) disable iff (reset)
    (req_valid && !req.wr_en && !(req.addr inside {`ADDR_SECOND_BUCK_MODE_ENABLE, `ADDR_SECOND_BUCK_LIMIT_SLEW,
      `ADDR_FIRST_BUCK_VOLTAGE_CODE, `ADDR_SECOND_BUCK_VOLTAGE_CODE, `ADDR_FIRST_LINEAR_CONTROL}))
      |=> rdata == 8'h00 && rdata_valid;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

  property p_mode_lands;
    @(posedge core_clk) disable iff (reset)
    s_write(`ADDR_SECOND_BUCK_MODE_ENABLE) |=> mode_r == ($past(req.wdata) & `MASK_SECOND_BUCK_MODE_ENABLE);
  endproperty
  a_mode_lands: assert property (p_mode_lands) else $error("mode write lost");

  property p_limit_lands;
    @(posedge core_clk) disable iff (reset)
    s_write(`ADDR_SECOND_BUCK_LIMIT_SLEW) |=> limit_r == ($past(req.wdata) & `MASK_SECOND_BUCK_LIMIT_SLEW);
  endproperty
  a_limit_lands: assert property (p_limit_lands) else $error("limit write lost");

  property p_first_vcode_lands;
    @(posedge core_clk) disable iff (reset)
    s_write(`ADDR_FIRST_BUCK_VOLTAGE_CODE) |=> vfirst_r == $past(req.wdata);
  endproperty
  a_first_vcode_lands: assert property (p_first_vcode_lands) else $error("first code write lost");

  property p_no_write_keeps;
    @(posedge core_clk) disable iff (reset)
    !(req_valid && req.wr_en) |=> $stable(mode_r) && $stable(limit_r) && $stable(vfirst_r)
      && $stable(vsecond_r) && $stable(linear_r);
  endproperty
  a_no_write_keeps: assert property (p_no_write_keeps) else $error("register moved without write");

endmodule : regulator_control_registers

// file: test/regulator_control_registers_tb.sv
// self-checking bench for the regulator control bank
`timescale 1ns/1ps
`include "regulator_control_map.svh"
module regulator_control_registers_tb
  import regulator_control_pkg::*;
;
  logic         core_clk = 0;
  logic         reset = 1;
  reg_req_s     req = '0;
  logic         req_valid = 0;
  logic         pin_cmd = 0;
  logic         enable_pin;
  logic [7:0]   rdata;
  logic         rdata_valid;
  buck_ctrl_s   buck_ctrl;
  logic [7:0]   first_buck_voltage_code;
  linear_ctrl_s linear_ctrl;
  logic         buck_running;
  logic         linear_running;
  int           fails = 0;
  int           samples_checked = 0;
  int           cycles = 0;
  logic [7:0]   codes [6] = '{8'h14, 8'h17, 8'h18, 8'h9d, 8'h9e, 8'hff};

  always #5 core_clk = ~core_clk;
  regulator_control_registers regulator_control_registers_i (.core_clk(core_clk), .reset(reset), .req(req),
    .req_valid(req_valid), .enable_pin(enable_pin), .rdata(rdata), .rdata_valid(rdata_valid),
    .buck_ctrl(buck_ctrl), .first_buck_voltage_code(first_buck_voltage_code), .linear_ctrl(linear_ctrl));
  regulator_core_model regulator_core_model_i (.pin_cmd(pin_cmd), .buck_ctrl(buck_ctrl),
    .linear_ctrl(linear_ctrl), .enable_pin(enable_pin), .buck_running(buck_running),
    .linear_running(linear_running));

  task automatic check(input string name, input logic [16:0] seen, input logic [16:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // one request held for exactly one taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1 req = '{1'b1, a, d};
    req_valid = 1;
    @(posedge core_clk);
    #1 req_valid = 0;
  endtask : wr
  task automatic rdchk(input string name, input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    #1 req = '{1'b0, a, 8'h00};
    req_valid = 1;
    @(posedge core_clk);
    #1 req_valid = 0;
    check({name, " valid"}, 17'(rdata_valid), 17'h1);
    check(name, 17'(rdata), 17'(exp));
  endtask : rdchk
  // lets controls and the synced pin land
  task automatic settle;
    repeat (4) @(posedge core_clk);
    #1;
  endtask : settle
  task automatic t_reset;
    rdchk("mode", `ADDR_SECOND_BUCK_MODE_ENABLE, 8'h07);
    rdchk("limit", `ADDR_SECOND_BUCK_LIMIT_SLEW, 8'h2a);
    rdchk("v0", `ADDR_FIRST_BUCK_VOLTAGE_CODE, 8'h59);
    rdchk("v1", `ADDR_SECOND_BUCK_VOLTAGE_CODE, 8'h59);
    rdchk("lin", `ADDR_FIRST_LINEAR_CONTROL, 8'h07);
    check("buck", 17'(buck_ctrl), {3'b010, 3'd5, 3'd2, 8'h59});
    check("lin out", 17'(linear_ctrl), 17'h2);
    pin_cmd = 1;
    settle();
    check("buck run", 17'(buck_ctrl.run), 17'h1);
    check("lin run", 17'(linear_ctrl.run), 17'h1);
    check("core buck", 17'(buck_running), 17'h1);
    check("core lin", 17'(linear_running), 17'h1);
  endtask : t_reset
  task automatic t_controls;
    wr(`ADDR_SECOND_BUCK_MODE_ENABLE, 8'h08);
    settle();
    check("mode out", 17'(buck_ctrl[16:14]), 17'h4);
    rdchk("mode rb", `ADDR_SECOND_BUCK_MODE_ENABLE, 8'h08);
    pin_cmd = 0;
    wr(`ADDR_SECOND_BUCK_MODE_ENABLE, 8'h03);
    settle();
    check("gated", 17'(buck_ctrl.run), 17'h0);
    check("core gated", 17'(buck_running), 17'h0);
    wr(`ADDR_SECOND_BUCK_MODE_ENABLE, 8'h01);
    wr(`ADDR_FIRST_LINEAR_CONTROL, 8'h01);
    settle();
    check("ungated", 17'(buck_ctrl.run), 17'h1);
    check("lin ungated", 17'(linear_ctrl.run), 17'h1);
    wr(`ADDR_FIRST_LINEAR_CONTROL, 8'h04);
    settle();
    check("lin off", 17'(linear_ctrl), 17'h2);
    wr(`ADDR_FIRST_LINEAR_CONTROL, 8'h00);
    settle();
    check("lin nodis", 17'(linear_ctrl), 17'h0);
  endtask : t_controls
  task automatic t_fields;
    for (int i = 0; i < 6; i++)
    begin
      wr(`ADDR_SECOND_BUCK_LIMIT_SLEW, {2'b00, 3'(i), 3'(i + 2)});
      settle();
      check("ilim", 17'(buck_ctrl.current_limit), 17'(i));
      check("slew", 17'(buck_ctrl.slew_select), 17'(i + 2));
    end
    for (int i = 0; i < 6; i++)
    begin
      logic [7:0] v1;
      v1 = ~codes[i] | 8'h80;
      wr(`ADDR_FIRST_BUCK_VOLTAGE_CODE, codes[i]);
      wr(`ADDR_SECOND_BUCK_VOLTAGE_CODE, v1);
      settle();
      check("v0 out", 17'(first_buck_voltage_code), 17'(codes[i]));
      check("v1 out", 17'(buck_ctrl.voltage_code), 17'(v1));
      rdchk("v0 rb", `ADDR_FIRST_BUCK_VOLTAGE_CODE, codes[i]);
    end
  endtask : t_fields
  task automatic t_refuse;
    wr(`ADDR_SECOND_BUCK_MODE_ENABLE, 8'h0f);
    wr(`ADDR_SECOND_BUCK_LIMIT_SLEW, 8'h2d);
    wr(`ADDR_FIRST_LINEAR_CONTROL, 8'h07);
    wr(8'h30, 8'h55);
    rdchk("mask m", `ADDR_SECOND_BUCK_MODE_ENABLE, 8'h0f);
    rdchk("mask l", `ADDR_SECOND_BUCK_LIMIT_SLEW, 8'h2d);
    rdchk("mask c", `ADDR_FIRST_LINEAR_CONTROL, 8'h07);
    rdchk("unmapped", 8'h30, 8'h00);
    rdchk("v0 kept", `ADDR_FIRST_BUCK_VOLTAGE_CODE, 8'hff);
  endtask : t_refuse
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run
  // cuts a hang short
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fails++;
      complete_run();
    end
  end
  initial
  begin
    repeat (12) @(posedge core_clk);
    #1 reset = 0;
    t_reset();
    t_controls();
    t_fields();
    t_refuse();
    complete_run();
  end
endmodule : regulator_control_registers_tb

// file: test/regulator_core_model.sv
// behavioural stand-in for the regulator cores and the external enable pin
`timescale 1ns/1ps
module regulator_core_model
  import regulator_control_pkg::*;
(
  input  wire logic         pin_cmd,        // pin level wanted by the bench
  input  wire buck_ctrl_s   buck_ctrl,      // second buck controls
  input  wire linear_ctrl_s linear_ctrl,    // first linear controls
  output logic              enable_pin,     // external enable pin
  output logic              buck_running,   // second buck output up
  output logic              linear_running  // first linear output up
);
  // pin is a plain level; cores follow their run controls
  assign enable_pin     = pin_cmd;
  assign buck_running   = buck_ctrl.run;
  assign linear_running = linear_ctrl.run;
endmodule : regulator_core_model
